// ==== hw/cpc_datapath.sv ====
// Overview of operation
// - preview resizer only shrinks, same ratio on both axes
// - colour decimation factor is programmed value over sixteen, 16 to 127; gray keeps every pixel
// - preview converts YCbCr to RGB with saturation
// - preview matrix R, G, B from offset-removed luma and chroma
// - preview colour pixels packed as RGB 5:5:5 halfwords
// - narrowing a channel drops its low-order bits
// - gray two per word: pixels at 31:20 and 15:4, low nibbles zero
// - gray one per word: pixel at 31:20, rest zero
// - each path has a FIFO buffering packed words, clocked like the rest by the bus clock
// - arbiter watches FIFO fill and picks burst length
// - descriptor is two words: buffer address, next descriptor
// - one frame per descriptor, then next descriptor loaded
// - linked list only on preview, starting at descriptor pointer
// - a frame is moved as many bursts
// - codec converter bypassed for YCbCr, converts RGB input
// - codec matrix Y, Cr, Cb with offsets
// - codec stores packed 32-bit words in scan order
// - codec writes each frame from the single base register
// - codec path unavailable in grayscale mode
// - burst mask 0 allows 4/8/16, 1 allows 8/16, 2 only 16
// - codec enable captures the next frame through codec path
`timescale 1ns/10ps
module cpc_fifo #(
	parameter int W  = 32,
	parameter int AW = 5
) (
	input  wire logic          clk,    // bus clock
	input  wire logic          rst_n,  // async reset
	input  wire logic          push,   // write one word
	input  wire logic [W-1:0]  din,    // word in
	input  wire logic          pop,    // read one word
	output logic      [W-1:0]  dout,   // head word
	output logic      [AW:0]   count,  // fill level
	output logic               full    // no room
);
	logic [W-1:0] mem [0:(1<<AW)-1];
	logic [AW:0]  wptr_reg;
	logic [AW:0]  rptr_reg;

	assign count = wptr_reg - rptr_reg;
	assign full  = (count == (AW+1)'(1 << AW));
	assign dout  = mem[rptr_reg[AW-1:0]];

	always_ff @(posedge clk) begin
		if (push && !full) begin
			mem[wptr_reg[AW-1:0]] <= din;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
		end else begin
			if (push && !full) begin
				wptr_reg <= wptr_reg + 1'b1;
			end
			if (pop && count != '0) begin
				rptr_reg <= rptr_reg + 1'b1;
			end
		end
	end
endmodule : cpc_fifo

module cpc_datapath (
	input  wire logic        REF_CLK,            // 50 MHz bus clock
	input  wire logic        RSTN,               // async reset, low
	input  wire logic        SENSOR_PIXEL_CLOCK, // sensor pixel clock
	input  wire logic        PIX_FRAME,          // frame active
	input  wire logic        PIX_LINE,           // line active
	input  wire logic [23:0] PIX_DATA,           // pixel components
	input  wire logic [7:0]  ADDR,               // register address
	input  wire logic [31:0] WDATA,              // register write data
	input  wire logic        WR,                 // write strobe
	input  wire logic        RD,                 // read strobe
	output logic      [31:0] RDATA,              // read data
	output logic      [1:0]  HTRANS,             // ahb transfer type
	output logic      [31:0] HADDR,              // ahb address
	output logic             HWRITE,             // ahb direction
	output logic      [2:0]  HSIZE,              // ahb size
	output logic      [2:0]  HBURST,             // ahb burst
	output logic      [31:0] HWDATA,             // ahb write data
	input  wire logic        HREADY,             // ahb ready
	input  wire logic [31:0] HRDATA              // ahb read data
);
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0]  ctrl_reg;
	logic [6:0]  decim_reg;
	logic [31:0] pdesc_reg, cbase_reg;
	logic [31:0] y2r0_reg, y2r1_reg, r2y0_reg, r2y1_reg, r2y2_reg;
	logic        codec_pend_reg, codec_act_reg, ovf_reg;
	logic [31:0] pv_addr_reg, cd_addr_reg, desc_ptr_reg;
	logic        desc_req_reg, desc_ok_reg;
	cpc_pkg::cpc_dma_t state_reg;
	logic        gray, rgb_in, pv_en;
	logic [1:0]  burst_threshold_mask;
	logic        frame_rise, frame_fall;

	assign gray   = ctrl_reg[cpc_pkg::CTL_GRAY];
	assign rgb_in = ctrl_reg[cpc_pkg::CTL_RGB_IN];
	assign pv_en  = ctrl_reg[cpc_pkg::CTL_PV_EN];
	assign burst_threshold_mask = ctrl_reg[cpc_pkg::CTL_THM_LO +: 2];

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ctrl_reg  <= cpc_pkg::CTRL_RST;
			decim_reg <= cpc_pkg::DECIM_RST;
			pdesc_reg <= '0;
			cbase_reg <= '0;
			y2r0_reg  <= cpc_pkg::Y2R0_RST;
			y2r1_reg  <= cpc_pkg::Y2R1_RST;
			r2y0_reg  <= cpc_pkg::R2Y0_RST;
			r2y1_reg  <= cpc_pkg::R2Y1_RST;
			r2y2_reg  <= cpc_pkg::R2Y2_RST;
		end else if (WR) begin
			case (ADDR)
				// codec enable bit is write-only
				cpc_pkg::ADDR_CTRL:  ctrl_reg  <= {WDATA[7:1], 1'b0};
				cpc_pkg::ADDR_DECIM: decim_reg <= WDATA[6:0];
				cpc_pkg::ADDR_PDESC: pdesc_reg <= WDATA;
				cpc_pkg::ADDR_CBASE: cbase_reg <= WDATA;
				cpc_pkg::ADDR_Y2R0:  y2r0_reg  <= WDATA;
				cpc_pkg::ADDR_Y2R1:  y2r1_reg  <= WDATA;
				cpc_pkg::ADDR_R2Y0:  r2y0_reg  <= WDATA;
				cpc_pkg::ADDR_R2Y1:  r2y1_reg  <= WDATA;
				cpc_pkg::ADDR_R2Y2:  r2y2_reg  <= WDATA;
				default: ;
			endcase
		end
	end

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			RDATA <= '0;
		end else if (RD) begin
			case (ADDR)
				cpc_pkg::ADDR_CTRL:  RDATA <= {24'h0, ctrl_reg};
				cpc_pkg::ADDR_DECIM: RDATA <= {25'h0, decim_reg};
				cpc_pkg::ADDR_PDESC: RDATA <= pdesc_reg;
				cpc_pkg::ADDR_CBASE: RDATA <= cbase_reg;
				cpc_pkg::ADDR_Y2R0:  RDATA <= y2r0_reg;
				cpc_pkg::ADDR_Y2R1:  RDATA <= y2r1_reg;
				cpc_pkg::ADDR_R2Y0:  RDATA <= r2y0_reg;
				cpc_pkg::ADDR_R2Y1:  RDATA <= r2y1_reg;
				cpc_pkg::ADDR_R2Y2:  RDATA <= r2y2_reg;
				cpc_pkg::ADDR_STAT:  RDATA <= {24'h0, desc_ok_reg,
					ovf_reg, codec_act_reg, codec_pend_reg,
					desc_req_reg, state_reg};
				cpc_pkg::ADDR_CURFB: RDATA <= pv_addr_reg;
				default:             RDATA <= '0;
			endcase
		end else begin
			RDATA <= '0;
		end
	end

	// ------------------------------------------------------------
	// pixel input sampling
	// ------------------------------------------------------------
	logic [26:0] s1_reg, s2_reg;
	logic        pck_d_reg, frame_d_reg, line_d_reg;
	logic        pix_ev, line_rise;
	logic [7:0]  ca, cb, cc;

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			s1_reg      <= '0;
			s2_reg      <= '0;
			pck_d_reg   <= 1'b0;
			frame_d_reg <= 1'b0;
			line_d_reg  <= 1'b0;
		end else begin
			s1_reg <= {SENSOR_PIXEL_CLOCK, PIX_FRAME, PIX_LINE, PIX_DATA};
			s2_reg      <= s1_reg;
			pck_d_reg   <= s2_reg[26];
			frame_d_reg <= s2_reg[25];
			line_d_reg  <= s2_reg[24];
		end
	end

	assign pix_ev     = s2_reg[26] && !pck_d_reg && s2_reg[25] && s2_reg[24];
	assign frame_rise = s2_reg[25] && !frame_d_reg;
	assign frame_fall = !s2_reg[25] && frame_d_reg;
	assign line_rise  = s2_reg[24] && !line_d_reg && s2_reg[25];
	assign ca = s2_reg[23:16];
	assign cb = s2_reg[15:8];
	assign cc = s2_reg[7:0];

	// ------------------------------------------------------------
	// preview resizer
	// ------------------------------------------------------------
	logic [7:0] h_ph_reg, v_ph_reg, h_sum, v_sum, dec8;
	logic       row_keep_reg, h_keep, pv_take;

	assign dec8   = {1'b0, decim_reg};
	assign h_sum  = h_ph_reg + cpc_pkg::PHASE_STEP;
	assign v_sum  = v_ph_reg + cpc_pkg::PHASE_STEP;
	assign h_keep = (h_sum >= dec8);
	// one ratio, never more outputs than inputs
	assign pv_take = pix_ev && pv_en && (gray || (row_keep_reg && h_keep));

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			h_ph_reg     <= '0;
			v_ph_reg     <= '0;
			row_keep_reg <= 1'b0;
		end else begin
			if (frame_rise) begin
				v_ph_reg <= dec8 - cpc_pkg::PHASE_STEP;
			end else if (line_rise) begin
				row_keep_reg <= (v_sum >= dec8);
				v_ph_reg     <= (v_sum >= dec8) ? v_sum - dec8 : v_sum;
			end
			if (line_rise) begin
				h_ph_reg <= dec8 - cpc_pkg::PHASE_STEP;
			end else if (pix_ev) begin
				h_ph_reg <= h_keep ? h_sum - dec8 : h_sum;
			end
		end
	end

	// ------------------------------------------------------------
	// colour conversion
	// ------------------------------------------------------------
	function automatic logic [7:0] sat8(input logic signed [19:0] v);
		logic signed [19:0] s;
		s = v >>> cpc_pkg::COEF_SHIFT;
		if (s < 0) begin
			return 8'h00;
		end else if (s > 20'sd255) begin
			return 8'hff;
		end
		return s[7:0];
	endfunction : sat8

	function automatic logic signed [19:0] sx(input logic [7:0] x);
		return $signed({12'h000, x});
	endfunction : sx

	logic signed [19:0] dy, dcb, dcr;
	logic signed [19:0] pr, pg, pb, qy, qr, qb;
	logic [23:0]        pv_rgb, cd_ycc;

	assign dy  = sx(ca) - sx(y2r1_reg[15:8]);
	assign dcb = sx(cb) - sx(y2r1_reg[23:16]);
	assign dcr = sx(cc) - sx(y2r1_reg[31:24]);
	assign pr = sx(y2r0_reg[7:0]) * dy + sx(y2r0_reg[15:8]) * dcr;
	assign pg = sx(y2r0_reg[7:0]) * dy - sx(y2r0_reg[23:16]) * dcb
		- sx(y2r0_reg[31:24]) * dcr;
	assign pb = sx(y2r0_reg[7:0]) * dy + sx(y2r1_reg[7:0]) * dcb;
	assign qy = sx(r2y0_reg[7:0]) * sx(ca) + sx(r2y0_reg[15:8]) * sx(cb)
		+ sx(r2y0_reg[23:16]) * sx(cc) + $signed({6'h0, r2y2_reg[15:8], 6'h0});
	assign qr = sx(r2y0_reg[31:24]) * sx(ca) - sx(r2y1_reg[7:0]) * sx(cb)
		- sx(r2y1_reg[15:8]) * sx(cc)
		+ $signed({6'h0, r2y2_reg[23:16], 6'h0});
	assign qb = sx(r2y2_reg[7:0]) * sx(cc) - sx(r2y1_reg[23:16]) * sx(ca)
		- sx(r2y1_reg[31:24]) * sx(cb)
		+ $signed({6'h0, r2y2_reg[31:24], 6'h0});
	assign pv_rgb = rgb_in ? s2_reg[23:0] : {sat8(pr), sat8(pg), sat8(pb)};
	// bypass for YCbCr input, ordered Y, Cb, Cr
	assign cd_ycc = rgb_in ? {sat8(qy), sat8(qb), sat8(qr)} : s2_reg[23:0];

	// ------------------------------------------------------------
	// word formatting
	// ------------------------------------------------------------
	logic [15:0] pv_hw, pv_hold_reg;
	logic [31:0] pv_word_reg, cd_word_reg;
	logic [23:0] cd_hold_reg;
	logic        pv_half_reg, pv_push_reg, cd_half_reg, cd_push_reg;
	logic        cd_take;

	// 5:5:5 by dropping low bits; gray layout
	assign pv_hw = gray ? {s2_reg[11:0], 4'h0}
		: {1'b0, pv_rgb[23:19], pv_rgb[15:11], pv_rgb[7:3]};
	assign cd_take = pix_ev && codec_act_reg && !gray;

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			pv_hold_reg <= '0;
			pv_word_reg <= '0;
			pv_half_reg <= 1'b0;
			pv_push_reg <= 1'b0;
		end else begin
			pv_push_reg <= 1'b0;
			if (frame_rise) begin
				pv_half_reg <= 1'b0;
			end else if (pv_take) begin
				if (gray && ctrl_reg[cpc_pkg::CTL_GPACK]) begin
					pv_word_reg <= {pv_hw, 16'h0};
					pv_push_reg <= 1'b1;
				end else if (!pv_half_reg) begin
					pv_hold_reg <= pv_hw;
					pv_half_reg <= 1'b1;
				end else begin
					// first gray pixel high; colour first pixel low
					pv_word_reg <= gray ? {pv_hold_reg, pv_hw}
						: {pv_hw, pv_hold_reg};
					pv_half_reg <= 1'b0;
					pv_push_reg <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			cd_hold_reg <= '0;
			cd_word_reg <= '0;
			cd_half_reg <= 1'b0;
			cd_push_reg <= 1'b0;
		end else begin
			cd_push_reg <= 1'b0;
			if (frame_rise) begin
				cd_half_reg <= 1'b0;
			end else if (cd_take) begin
				if (!cd_half_reg) begin
					cd_hold_reg <= cd_ycc;
					cd_half_reg <= 1'b1;
				end else begin
					// packed Y1 Cr Y0 Cb in scan order
					cd_word_reg <= {cd_ycc[23:16], cd_hold_reg[7:0],
						cd_hold_reg[23:16], cd_hold_reg[15:8]};
					cd_half_reg <= 1'b0;
					cd_push_reg <= 1'b1;
				end
			end
		end
	end

	// codec armed by write, active for the next whole frame
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			codec_pend_reg <= 1'b0;
			codec_act_reg  <= 1'b0;
		end else begin
			if (frame_rise && codec_pend_reg) begin
				codec_pend_reg <= 1'b0;
				codec_act_reg  <= 1'b1;
			end else if (frame_fall) begin
				codec_act_reg <= 1'b0;
			end
			if (WR && ADDR == cpc_pkg::ADDR_CTRL
				&& WDATA[cpc_pkg::CTL_CODEC_ON] && !WDATA[cpc_pkg::CTL_GRAY]) begin
				codec_pend_reg <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// fifos and arbiter
	// ------------------------------------------------------------
	logic [31:0] pv_dout, cd_dout;
	logic [5:0]  pv_cnt, cd_cnt;
	logic        pv_full, cd_full, pv_pop, cd_pop, path_reg;
	logic [4:0]  pv_len, cd_len, beats_reg;
	logic [2:0]  pv_hb, cd_hb;

	// per-path buffering of packed words, on the bus clock
	cpc_fifo #(.W(32), .AW(cpc_pkg::FIFO_AW)) u_pv_fifo (
		.clk(REF_CLK), .rst_n(RSTN), .push(pv_push_reg),
		.din(pv_word_reg), .pop(pv_pop), .dout(pv_dout),
		.count(pv_cnt), .full(pv_full));
	cpc_fifo #(.W(32), .AW(cpc_pkg::FIFO_AW)) u_cd_fifo (
		.clk(REF_CLK), .rst_n(RSTN), .push(cd_push_reg),
		.din(cd_word_reg), .pop(cd_pop), .dout(cd_dout),
		.count(cd_cnt), .full(cd_full));

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ovf_reg <= 1'b0;
		end else if ((pv_push_reg && pv_full) || (cd_push_reg && cd_full)) begin
			ovf_reg <= 1'b1;
		end else if (WR && ADDR == cpc_pkg::ADDR_STAT) begin
			ovf_reg <= 1'b0;
		end
	end

	// burst length from fill and mask; partial at frame end
	function automatic logic [7:0] pick(input logic [5:0] n,
		input logic [1:0] m, input logic flush);
		if (n >= 6'd16) begin
			return {cpc_pkg::HB_INCR16, cpc_pkg::LEN16};
		end else if (n >= 6'd8 && m < 2'd2) begin
			return {cpc_pkg::HB_INCR8, cpc_pkg::LEN8};
		end else if (n >= 6'd4 && m == 2'd0) begin
			return {cpc_pkg::HB_INCR4, cpc_pkg::LEN4};
		end else if (flush && n != 6'd0) begin
			return {cpc_pkg::HB_INCR, n[4:0]};
		end
		return 8'h00;
	endfunction : pick

	assign {pv_hb, pv_len} = pick(pv_cnt, burst_threshold_mask, !s2_reg[25]);
	assign {cd_hb, cd_len} = pick(cd_cnt, burst_threshold_mask, !codec_act_reg);
	assign pv_pop = state_reg == cpc_pkg::DMA_BURST && HREADY && !path_reg;
	assign cd_pop = state_reg == cpc_pkg::DMA_BURST && HREADY && path_reg;

	// ------------------------------------------------------------
	// ahb master
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_reg    <= cpc_pkg::DMA_IDLE;
			HTRANS       <= cpc_pkg::HT_IDLE;
			HADDR        <= '0;
			HWRITE       <= 1'b0;
			HSIZE        <= cpc_pkg::HS_WORD;
			HBURST       <= cpc_pkg::HB_INCR;
			HWDATA       <= '0;
			beats_reg    <= '0;
			path_reg     <= 1'b0;
			pv_addr_reg  <= '0;
			cd_addr_reg  <= '0;
			desc_ptr_reg <= '0;
			desc_req_reg <= 1'b0;
			desc_ok_reg  <= 1'b0;
		end else begin
			case (state_reg)
				cpc_pkg::DMA_IDLE: begin
					if (desc_req_reg) begin
						desc_req_reg <= 1'b0;
						HADDR  <= desc_ptr_reg;
						HTRANS <= cpc_pkg::HT_NONSEQ;
						HWRITE <= 1'b0;
						HBURST <= cpc_pkg::HB_INCR;
						state_reg <= cpc_pkg::DMA_DESC_A;
					end else if (cd_len != '0) begin
						// codec writes from its own address
						path_reg  <= 1'b1;
						HADDR     <= cd_addr_reg;
						HTRANS    <= cpc_pkg::HT_NONSEQ;
						HWRITE    <= 1'b1;
						HBURST    <= cd_hb;
						beats_reg <= cd_len;
						state_reg <= cpc_pkg::DMA_BURST;
					end else if (pv_len != '0 && desc_ok_reg) begin
						path_reg  <= 1'b0;
						HADDR     <= pv_addr_reg;
						HTRANS    <= cpc_pkg::HT_NONSEQ;
						HWRITE    <= 1'b1;
						HBURST    <= pv_hb;
						beats_reg <= pv_len;
						state_reg <= cpc_pkg::DMA_BURST;
					end
				end
				cpc_pkg::DMA_DESC_A: if (HREADY) begin
					HADDR     <= HADDR + cpc_pkg::WORD_STEP;
					HTRANS    <= cpc_pkg::HT_SEQ;
					state_reg <= cpc_pkg::DMA_DESC_B;
				end
				cpc_pkg::DMA_DESC_B: if (HREADY) begin
					// first word is this frame's buffer
					pv_addr_reg <= HRDATA;
					HTRANS      <= cpc_pkg::HT_IDLE;
					state_reg   <= cpc_pkg::DMA_DESC_C;
				end
				cpc_pkg::DMA_DESC_C: if (HREADY) begin
					// second word points at the next one
					desc_ptr_reg <= HRDATA;
					desc_ok_reg  <= 1'b1;
					state_reg    <= cpc_pkg::DMA_IDLE;
				end
				cpc_pkg::DMA_BURST: if (HREADY) begin
					HWDATA    <= path_reg ? cd_dout : pv_dout;
					HADDR     <= HADDR + cpc_pkg::WORD_STEP;
					beats_reg <= beats_reg - 1'b1;
					if (path_reg) begin
						cd_addr_reg <= HADDR + cpc_pkg::WORD_STEP;
					end else begin
						pv_addr_reg <= HADDR + cpc_pkg::WORD_STEP;
					end
					if (beats_reg == 5'd1) begin
						HTRANS    <= cpc_pkg::HT_IDLE;
						state_reg <= cpc_pkg::DMA_DRAIN;
					end else begin
						HTRANS <= cpc_pkg::HT_SEQ;
					end
				end
				cpc_pkg::DMA_DRAIN: if (HREADY) begin
					state_reg <= cpc_pkg::DMA_IDLE;
				end
				default: state_reg <= cpc_pkg::DMA_IDLE;
			endcase
			if (frame_rise && codec_pend_reg) begin
				cd_addr_reg <= cbase_reg;
			end
			// list starts at the descriptor pointer register
			if (WR && ADDR == cpc_pkg::ADDR_PDESC) begin
				desc_ptr_reg <= WDATA;
				desc_ok_reg  <= 1'b0;
			end
			if (frame_rise && pv_en) begin
				desc_req_reg <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	unity_ratio_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(pix_ev && decim_reg == 7'd16) |-> h_keep)
		else $error("unity decimation skipped a pixel");
	no_upscale_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		pv_take |=> !pv_take [*3])
		else $error("preview output faster than pixel clock");
	gray_single_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(pv_push_reg && gray && ctrl_reg[cpc_pkg::CTL_GPACK])
		|-> pv_word_reg[19:0] == 20'h0)
		else $error("gray single word low bits not zero");
	gray_pair_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(pv_push_reg && gray && !ctrl_reg[cpc_pkg::CTL_GPACK])
		|-> pv_word_reg[19:16] == 4'h0 && pv_word_reg[3:0] == 4'h0)
		else $error("gray pair nibbles not zero");
	rgb_trunc_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(pv_take && !gray && !pv_half_reg)
		|=> pv_hold_reg[14:10] == $past(pv_rgb[23:19]))
		else $error("red field not truncated");
	burst_mask_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(HTRANS == cpc_pkg::HT_NONSEQ && HBURST == cpc_pkg::HB_INCR4)
		|-> burst_threshold_mask == 2'd0)
		else $error("four beat burst not permitted");
	desc_pair_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(state_reg == cpc_pkg::DMA_DESC_A && HREADY)
		|=> HADDR == $past(HADDR) + cpc_pkg::WORD_STEP)
		else $error("descriptor words not adjacent");
	codec_base_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(frame_rise && codec_pend_reg) |=> cd_addr_reg == $past(cbase_reg)
		&& codec_act_reg)
		else $error("codec frame not started at base");
	codec_gray_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		gray |=> !cd_push_reg)
		else $error("codec word pushed in grayscale");
endmodule : cpc_datapath

// ==== hw/cpc_pkg.sv ====
package cpc_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_DECIM  = 8'h04;
	localparam logic [7:0]  ADDR_PDESC  = 8'h08;
	localparam logic [7:0]  ADDR_CBASE  = 8'h0c;
	localparam logic [7:0]  ADDR_Y2R0   = 8'h10;
	localparam logic [7:0]  ADDR_Y2R1   = 8'h14;
	localparam logic [7:0]  ADDR_R2Y0   = 8'h18;
	localparam logic [7:0]  ADDR_R2Y1   = 8'h1c;
	localparam logic [7:0]  ADDR_R2Y2   = 8'h20;
	localparam logic [7:0]  ADDR_STAT   = 8'h24;
	localparam logic [7:0]  ADDR_CURFB  = 8'h28;
	// control bit positions
	localparam int          CTL_CODEC_ON = 0;
	localparam int          CTL_THM_LO   = 1;
	localparam int          CTL_GRAY     = 3;
	localparam int          CTL_GPACK    = 4;
	localparam int          CTL_RGB_IN   = 5;
	localparam int          CTL_PV_EN    = 6;
	// reset values, coefficients in 1/64 units
	localparam logic [7:0]  CTRL_RST    = 8'h00;
	localparam logic [6:0]  DECIM_RST   = 7'h10;
	localparam logic [31:0] Y2R0_RST    = 32'h3419664a;
	localparam logic [31:0] Y2R1_RST    = 32'h80801087;
	localparam logic [31:0] R2Y0_RST    = 32'h1c062010;
	localparam logic [31:0] R2Y1_RST    = 32'h13090518;
	localparam logic [31:0] R2Y2_RST    = 32'h8080101c;
	localparam int          COEF_SHIFT  = 6;
	localparam logic [7:0]  PHASE_STEP  = 8'h10;
	// buffering and bursts
	localparam int          FIFO_AW     = 5;
	localparam logic [4:0]  LEN4        = 5'h04;
	localparam logic [4:0]  LEN8        = 5'h08;
	localparam logic [4:0]  LEN16       = 5'h10;
	localparam logic [1:0]  HT_IDLE     = 2'h0;
	localparam logic [1:0]  HT_NONSEQ   = 2'h2;
	localparam logic [1:0]  HT_SEQ      = 2'h3;
	localparam logic [2:0]  HB_INCR     = 3'h1;
	localparam logic [2:0]  HB_INCR4    = 3'h3;
	localparam logic [2:0]  HB_INCR8    = 3'h5;
	localparam logic [2:0]  HB_INCR16   = 3'h7;
	localparam logic [2:0]  HS_WORD     = 3'h2;
	localparam logic [31:0] WORD_STEP   = 32'h4;
	typedef enum logic [2:0] {
		DMA_IDLE   = 3'h0,
		DMA_DESC_A = 3'h1,
		DMA_DESC_B = 3'h3,
		DMA_DESC_C = 3'h2,
		DMA_BURST  = 3'h6,
		DMA_DRAIN  = 3'h7
	} cpc_dma_t;
endpackage : cpc_pkg

// ==== testbench/cpc_mem_model.sv ====
`timescale 1ns/10ps
module cpc_mem_model (
	input  wire logic        clk,    // bus clock
	input  wire logic        slow,   // wait states
	input  wire logic [1:0]  htrans, // transfer type
	input  wire logic [31:0] haddr,  // address
	input  wire logic        hwrite, // direction
	input  wire logic [31:0] hwdata, // write data
	output logic             hready, // ready
	output logic      [31:0] hrdata  // read data
);
	logic [31:0] mem [0:255];
	logic        ph = 1'b0;
	logic        dv = 1'b0;
	logic        dw = 1'b0;
	logic [7:0]  da = 8'h00;
	assign hready = slow ? ph : 1'b1;
	assign hrdata = (dv && !dw) ? mem[da] : {32{ph}};
	always @(posedge clk) begin
		ph <= !ph;
		if (hready) begin
			if (dv && dw)
				mem[da] <= hwdata;
			dv <= htrans[1];
			dw <= hwrite;
			da <= haddr[9:2];
		end
	end
endmodule : cpc_mem_model

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        pclk = 1'b0;
	logic        frm = 1'b0;
	logic        lin = 1'b0;
	logic [23:0] pd = 24'h000000;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        slow = 1'b0;
	logic [31:0] rdata, haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize, hburst;
	logic        hwrite, hready;
	int          failures = 0;
	int          n_tests = 0;
	always #10 clk = !clk;
	cpc_datapath dut (.REF_CLK(clk), .RSTN(rstn), .SENSOR_PIXEL_CLOCK(pclk),
		.PIX_FRAME(frm), .PIX_LINE(lin), .PIX_DATA(pd), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .HTRANS(htrans),
		.HADDR(haddr), .HWRITE(hwrite), .HSIZE(hsize), .HBURST(hburst),
		.HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata));
	cpc_mem_model memory (.clk(clk), .slow(slow), .htrans(htrans),
		.haddr(haddr), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata));
	task automatic wrap_up;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask : rd_reg
	task automatic pix(input logic [23:0] d);
		pd <= d;
		repeat (4) @(posedge clk);
		pclk <= 1'b1;
		repeat (4) @(posedge clk);
		pclk <= 1'b0;
	endtask : pix
	// frame of two pixels, pixel clock still outside it
	task automatic frame(input logic [23:0] p0, input logic [23:0] p1);
		@(posedge clk);
		frm <= 1'b1;
		repeat (30) @(posedge clk);
		lin <= 1'b1;
		pix(p0);
		pix(p1);
		lin <= 1'b0;
		repeat (4) @(posedge clk);
		frm <= 1'b0;
		repeat (80) @(posedge clk);
	endtask : frame
	initial begin
		memory.mem[16] = 32'h00000100;
		memory.mem[17] = 32'h00000048;
		memory.mem[18] = 32'h00000200;
		memory.mem[19] = 32'h00000040;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rd_reg(8'h04, 32'h00000010);
		wr_reg(8'h04, 32'h0000007f);
		rd_reg(8'h04, 32'h0000007f);
		rd_reg(8'hfc, 32'h00000000);
		$display("register test done");
		wr_reg(8'h08, 32'h00000040);
		wr_reg(8'h00, 32'h00000048);
		frame(24'h000abc, 24'h000123);
		chk(memory.mem[64], 32'habc01230);
		$display("gray pair test done");
		slow <= 1'b1;
		wr_reg(8'h00, 32'h00000058);
		frame(24'h0005a7, 24'h0003c9);
		chk(memory.mem[128], 32'h5a700000);
		chk(memory.mem[129], 32'h3c900000);
		$display("gray single test done");
		wr_reg(8'h04, 32'h00000010);
		wr_reg(8'h0c, 32'h00000300);
		wr_reg(8'h00, 32'h00000041);
		frame(24'hff80ff, 24'h10ff00);
		chk(memory.mem[64], 32'h00df7ebf);
		chk(memory.mem[192], 32'h10ffff80);
		rd_reg(8'h28, 32'h00000104);
		chk({29'h0, hburst}, 32'h00000001);
		chk({29'h0, hsize}, 32'h00000002);
		$display("colour and codec test done");
		wrap_up();
	end
	initial begin
		#100000;
		failures++;
		wrap_up();
	end
endmodule : tb_top
